/* File: src/pwc_pkg.sv */
package pwc_pkg;
  // Register byte offsets (one aligned word each)
  localparam logic [3:0] OFS_PRESCALE = 4'h0;
  localparam logic [3:0] OFS_MODE = 4'h4;
  localparam logic [3:0] OFS_CCCTRL = 4'h8;
  localparam logic [3:0] OFS_COUNT = 4'hC;
  localparam logic [4:0] OFS_CCA = 5'h10;
  localparam logic [4:0] OFS_CCB = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;
  localparam logic [4:0] OFS_MASK = 5'h1C;
  localparam int ADDR_W = 5;
  // Prescaler mode register fields
  localparam int CLK_SEL_LSB = 0;
  localparam int EDGE_A_LSB = 4;
  localparam int EDGE_B_LSB = 6;
  // Capture/compare control fields
  localparam int A_CAP_BIT = 0;
  localparam int A_TRIG_BIT = 1;
  localparam int B_CAP_BIT = 2;
  // Status bits
  localparam int ST_A = 0;
  localparam int ST_B = 1;
  localparam int ST_OVF = 2;
  localparam int ST_W = 3;
  // Edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Count clock choices: clk divided by 1, 4 or 64, or valid edge A as external clock
  localparam logic [1:0] CLK_DIV1 = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_DIV64 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam int PRE_W = 6;
  localparam logic [PRE_W-1:0] DIV4_MASK = 6'h03;
  localparam logic [PRE_W-1:0] DIV64_MASK = 6'h3F;
  localparam logic [PRE_W-1:0] DIV8_MASK = 6'h07;
  // Reset values
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [7:0] CCCTRL_RST = 8'h00;
  localparam logic [15:0] CC_RST = 16'h0000;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_STOP, MODE_FREE, MODE_RESTART, MODE_EVENT
  } pwc_mode_e;
  // Avalon request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
  } pwc_req_s;
endpackage

/* File: src/pwc_edge_filter.sv */
`timescale 1ns/100ps
module pwc_edge_filter
  import pwc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sample,
  // Pin and edge choice
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  // Filtered edges
  output logic rise,
  output logic fall,
  output logic valid
);
  logic s1_q, s1_d, s2_q, s2_d, lvl_q, lvl_d;

  // Level accepted only when two samples agree
  always_comb begin
    s1_d = s1_q;
    s2_d = s2_q;
    lvl_d = lvl_q;
    if (sample) begin
      s1_d = pin;
      s2_d = s1_q;
      if (s1_q == s2_q) begin
        lvl_d = s2_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      lvl_q <= 1'b0;
    end else if (ce) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      lvl_q <= lvl_d;
    end
  end

  // Edge decode on filtered level
  assign rise = lvl_d & ~lvl_q;
  assign fall = ~lvl_d & lvl_q;
  assign valid = (edge_sel == EDGE_RISE) ? rise :
                 (edge_sel == EDGE_FALL) ? fall :
                 (edge_sel == EDGE_BOTH) ? (rise | fall) : 1'b0;
endmodule

/* File: src/pwc_capture.sv */
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
// Operation
// - free-running, valid edge A copies counter to register B, irq B.
// - bits 5:4 of prescaler mode pick edge A valid edge.
// - valid edge B (bits 7:6) copies counter to register A, irq A.
// - capture inputs sampled on count clock (clk divided by eight with external clock), need two equal samples.
// - reverse-phase edge A captures into register A.
// - both-edge select blocks reverse-phase capture into register A.
// - restart mode: capture into register B, then clear counter.
// - event mode: counter steps on each valid edge A.
// - event count equal to register A clears counter, irq A.
// - event mode samples edge A at clock divided by eight.
// - mode bit 1 capture, 0 compare; trigger bit picks A source.
// - edge codes 00 fall, 01 rise, 11 both, 10 prohibited.
module pwc_capture
  import pwc_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Edge pins
  input wire logic edge_input_a,
  input wire logic edge_input_b,
  // Interrupt
  output logic irq
);
  pwc_req_s req;
  logic [7:0] prescaler_mode_reg_q, prescaler_mode_reg_d;
  logic [2:0] capture_compare_ctrl_q, capture_compare_ctrl_d;
  pwc_mode_e mode_q, mode_d;
  logic [15:0] main_counter_q, main_counter_d;
  logic [15:0] capture_compare_a_q, capture_compare_a_d;
  logic [15:0] capture_compare_b_q, capture_compare_b_d;
  logic [ST_W-1:0] status_q, status_d, mask_q, mask_d, ev;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic run, cnt_tick, smp, smp8;
  logic [1:0] edge_a_sel, edge_b_sel, clk_sel;
  logic a_rise, a_fall, a_valid, b_valid;
  logic a_rev, cap_a, cap_b, step, clear, hit;

  assign req = '{avs_read, avs_write, avs_address, avs_writedata};
  assign run = (mode_q != MODE_STOP);
  assign edge_a_sel = prescaler_mode_reg_q[EDGE_A_LSB +: 2];
  assign edge_b_sel = prescaler_mode_reg_q[EDGE_B_LSB +: 2];
  assign clk_sel = prescaler_mode_reg_q[CLK_SEL_LSB +: 2];

  // Prescaler; free-runs so the divider phases stay steady
  always_comb begin
    pre_d = pre_q + 6'h01;
  end
  // count clock doubles as sample strobe
  always_comb begin
    case (clk_sel)
      CLK_DIV1: cnt_tick = 1'b1;
      CLK_DIV4: cnt_tick = ((pre_q & DIV4_MASK) == DIV4_MASK);
      CLK_DIV64: cnt_tick = ((pre_q & DIV64_MASK) == DIV64_MASK);
      default: cnt_tick = 1'b0;
    endcase
  end
  // event mode filters edge A at clock divided by eight
  assign smp8 = ((pre_q & DIV8_MASK) == DIV8_MASK);
  assign smp = (mode_q == MODE_EVENT || clk_sel == CLK_EXT) ? smp8 : cnt_tick;

  // Noise filter for edge A
  pwc_edge_filter u_filt_a (
    .clk(clk),
    .rst(rst),
    .ce(ce & run),
    .sample(smp),
    .pin(edge_input_a),
    .edge_sel(edge_a_sel),
    .rise(a_rise),
    .fall(a_fall),
    .valid(a_valid)
  );
  // Noise filter for edge B
  pwc_edge_filter u_filt_b (
    .clk(clk),
    .rst(rst),
    .ce(ce & run),
    .sample(smp),
    .pin(edge_input_b),
    .edge_sel(edge_b_sel),
    .rise(),
    .fall(),
    .valid(b_valid)
  );

  // Capture and count decisions
  always_comb begin
    // reverse-phase of the selected single edge
    // both-edge select gives no reverse edge
    a_rev = (edge_a_sel == EDGE_RISE) ? a_fall :
            (edge_a_sel == EDGE_FALL) ? a_rise : 1'b0; // blocks both
    // register B capture only in capture mode
    cap_b = run && mode_q != MODE_EVENT && a_valid &&
            capture_compare_ctrl_q[B_CAP_BIT];
    // edge B or reverse edge A, chosen by trigger bit
    cap_a = run && mode_q != MODE_EVENT &&
            capture_compare_ctrl_q[A_CAP_BIT] &&
            (capture_compare_ctrl_q[A_TRIG_BIT] ? a_rev : b_valid);
    // event mode steps on valid edge A
    step = (mode_q == MODE_EVENT) ? a_valid :
           (run && clk_sel != CLK_EXT) ? cnt_tick :
           (run && a_valid);
    hit = (mode_q == MODE_EVENT) && step &&
          !capture_compare_ctrl_q[A_CAP_BIT] &&
          (main_counter_q + 16'h0001 == capture_compare_a_q);
    // restart on valid edge A after capture
    clear = (mode_q == MODE_RESTART) && a_valid;
  end

  // Counter and capture registers
  always_comb begin
    main_counter_d = main_counter_q;
    capture_compare_a_d = capture_compare_a_q;
    capture_compare_b_d = capture_compare_b_q;
    ev = '0;
    if (!run) begin
      main_counter_d = 16'h0000;
    end else if (clear || hit) begin
      main_counter_d = 16'h0000;
    end else if (step) begin
      main_counter_d = main_counter_q + 16'h0001;
      ev[ST_OVF] = (main_counter_q == 16'hFFFF);
    end
    if (cap_b) begin
      capture_compare_b_d = main_counter_q;
      ev[ST_B] = 1'b1;
    end
    if (cap_a) begin
      capture_compare_a_d = main_counter_q;
      ev[ST_A] = 1'b1;
    end
    if (hit) begin
      ev[ST_A] = 1'b1;
    end
    // Bus writes land on the completing edge; capture has priority
    if (req.write && ack_q) begin
      if (req.address == OFS_CCA && !cap_a) begin
        capture_compare_a_d = req.writedata[15:0];
      end
      if (req.address == OFS_CCB && !cap_b) begin
        capture_compare_b_d = req.writedata[15:0];
      end
    end
  end

  // Register writes, sticky status with set over clear
  always_comb begin
    prescaler_mode_reg_d = prescaler_mode_reg_q;
    capture_compare_ctrl_d = capture_compare_ctrl_q;
    mode_d = mode_q;
    mask_d = mask_q;
    status_d = status_q;
    // Write acts at the edge where waitrequest is seen low
    if (req.write && ack_q) begin
      case (req.address)
        {1'b0, OFS_PRESCALE}: prescaler_mode_reg_d = req.writedata[7:0];
        {1'b0, OFS_CCCTRL}: capture_compare_ctrl_d = req.writedata[2:0];
        {1'b0, OFS_MODE}: mode_d = pwc_mode_e'(req.writedata[1:0]);
        OFS_MASK: mask_d = req.writedata[ST_W-1:0];
        OFS_STATUS: status_d = status_q & ~req.writedata[ST_W-1:0];
        default: begin
        end
      endcase
    end
    status_d = status_d | ev;
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (req.address)
      {1'b0, OFS_PRESCALE}: rdata_d[7:0] = prescaler_mode_reg_q;
      {1'b0, OFS_MODE}: rdata_d[1:0] = mode_q;
      {1'b0, OFS_CCCTRL}: rdata_d[2:0] = capture_compare_ctrl_q;
      {1'b0, OFS_COUNT}: rdata_d[15:0] = main_counter_q;
      OFS_CCA: rdata_d[15:0] = capture_compare_a_q;
      OFS_CCB: rdata_d[15:0] = capture_compare_b_q;
      OFS_STATUS: rdata_d[ST_W-1:0] = status_q;
      OFS_MASK: rdata_d[ST_W-1:0] = mask_q;
      default: rdata_d = 32'h0000_0000;
    endcase
    ack_d = (req.read || req.write) && !ack_q;
  end

  // One wait state per access
  assign avs_waitrequest = (req.read || req.write) && !ack_q;
  assign avs_readdata = rdata_q;
  assign irq = |(status_q & mask_q);

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      prescaler_mode_reg_q <= PRESCALE_RST;
      capture_compare_ctrl_q <= CCCTRL_RST[2:0];
      mode_q <= MODE_STOP;
      main_counter_q <= CC_RST;
      capture_compare_a_q <= CC_RST;
      capture_compare_b_q <= CC_RST;
      status_q <= '0;
      mask_q <= '0;
      pre_q <= '0;
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else if (ce) begin
      prescaler_mode_reg_q <= prescaler_mode_reg_d;
      capture_compare_ctrl_q <= capture_compare_ctrl_d;
      mode_q <= mode_d;
      main_counter_q <= main_counter_d;
      capture_compare_a_q <= capture_compare_a_d;
      capture_compare_b_q <= capture_compare_b_d;
      status_q <= status_d;
      mask_q <= mask_d;
      pre_q <= pre_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  // a hit always returns the counter to zero
  a_hit_clears: assert property (@(posedge clk) disable iff (rst)
    ce && hit |=> main_counter_q == 16'h0000)
    else $error("compare hit did not clear counter");
  // a hit also raises the register A request
  a_hit_irq: assert property (@(posedge clk) disable iff (rst)
    ce && hit |=> status_q[ST_A])
    else $error("compare hit did not flag status");
  // capture into B latches counter and flags status
  a_cap_b_val: assert property (@(posedge clk) disable iff (rst)
    ce && cap_b |=> capture_compare_b_q == $past(main_counter_q)
    && status_q[ST_B])
    else $error("register B capture wrong");
  // register B in compare mode is never loaded by hardware
  a_b_hold: assert property (@(posedge clk) disable iff (rst)
    ce && !capture_compare_ctrl_q[B_CAP_BIT] && !(req.write && ack_q)
    |=> $stable(capture_compare_b_q))
    else $error("register B changed in compare mode");
  a_cap_a_val: assert property (@(posedge clk) disable iff (rst)
    ce && cap_a |=> capture_compare_a_q == $past(main_counter_q)
    && status_q[ST_A])
    else $error("register A capture wrong");
  // captures only fall on a sample strobe
  a_cap_smp: assert property (@(posedge clk) disable iff (rst)
    cap_a || cap_b |-> smp)
    else $error("capture outside the sample strobe");
  // reverse capture into A comes from the opposite edge
  a_rev_edge: assert property (@(posedge clk) disable iff (rst)
    cap_a && capture_compare_ctrl_q[A_TRIG_BIT] |-> !a_valid)
    else $error("reverse capture on the selected edge");
  // both-edge select never reverse-captures into A
  a_both_noa: assert property (@(posedge clk) disable iff (rst)
    edge_a_sel == EDGE_BOTH && capture_compare_ctrl_q[A_TRIG_BIT]
    |-> !cap_a)
    else $error("reverse capture with both edges");
  // restart edge first, then counter at zero with B flagged
  sequence s_restart_edge;
    ce && clear && capture_compare_ctrl_q[B_CAP_BIT];
  endsequence
  sequence s_restart_done;
    main_counter_q == 16'h0000 && status_q[ST_B];
  endsequence
  a_restart_clr: assert property (@(posedge clk) disable iff (rst)
    s_restart_edge |=> s_restart_done)
    else $error("restart did not capture and clear");
  a_free_wrap: assert property (@(posedge clk) disable iff (rst)
    ce && step && !clear && !hit && main_counter_q == 16'hFFFF
    |=> main_counter_q == 16'h0000 && status_q[ST_OVF])
    else $error("counter did not wrap");
  // event mode counts only on valid edges
  a_event_hold: assert property (@(posedge clk) disable iff (rst)
    ce && mode_q == MODE_EVENT && !a_valid && !(req.write && ack_q)
    |=> $stable(main_counter_q))
    else $error("event counter moved without edge");
  // each counted edge other than a compare hit adds exactly one
  a_event_step: assert property (@(posedge clk) disable iff (rst)
    ce && mode_q == MODE_EVENT && step && !hit
    |=> main_counter_q == $past(main_counter_q) + 16'h0001)
    else $error("event counter did not step by one");
  // event edges only on the divide-by-eight strobe
  a_event_smp: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_EVENT && a_valid |-> smp8)
    else $error("event edge outside the sample strobe");
  // prohibited edge code gives no edges
  a_code_bad: assert property (@(posedge clk) disable iff (rst)
    edge_a_sel == 2'h2 |-> !a_valid)
    else $error("prohibited edge code produced an edge");
endmodule

/* File: dv/pwc_pulse_model.sv */
`timescale 1ns/100ps
module pwc_pulse_model (
  // Clock
  input wire logic clk,
  // Levels asked for by the bench
  input wire logic lvl_a,
  input wire logic lvl_b,
  // Pulse pins
  output logic edge_input_a,
  output logic edge_input_b
);
  // Pins move just after a clock edge, as a synchronous source would
  always_ff @(posedge clk) begin
    edge_input_a <= lvl_a;
    edge_input_b <= lvl_b;
  end
endmodule

/* File: dv/pulse_width_capture_event_counter_tb_top.sv */
`timescale 1ns/100ps
module pulse_width_capture_event_counter_tb_top;
  import pwc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0] wd = '0;
  logic [31:0] rdata;
  logic wait_req;
  logic irq;
  logic pa;
  logic pb;
  logic la = 1'b0;
  logic lb = 1'b0;
  logic ce = 1'b1;
  logic [31:0] seed = 32'h260E7273;
  logic [31:0] v;
  logic [15:0] b;
  logic [1:0] code;
  int n_errors = 0;
  int tests_run = 0;
  int w;
  // Free-running bench clock, 50 ns period
  always #25 clk = ~clk;
  pwc_pulse_model model (.clk(clk), .lvl_a(la), .lvl_b(lb),
    .edge_input_a(pa), .edge_input_b(pb));
  // Design under test; ce comes from the bench so freezes can be tried
  pwc_capture dut (.clk(clk), .rst(rst), .ce(ce), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdata), .avs_waitrequest(wait_req),
    .edge_input_a(pa), .edge_input_b(pb), .irq(irq));
  // Xorshift step for repeatable widths
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w_en, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    rd <= ~w_en;
    wr <= w_en;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wait_req !== 1'b0) begin
      @(posedge clk);
    end
    v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // Idle edge so the next call never reassigns in this time step
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // High for hi cycles, then low for lo cycles
  task automatic pulse_a(input int hi, input int lo);
    la <= 1'b1;
    repeat (hi) @(posedge clk);
    la <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask
  // Stop, load edges and control, then start a mode
  task automatic setup(input logic [7:0] pre, input logic [7:0] ctl,
                       input logic [7:0] mode);
    bus(1'b1, {1'b0, OFS_MODE}, 32'h0);
    bus(1'b1, {1'b0, OFS_PRESCALE}, {24'h0, pre});
    bus(1'b1, {1'b0, OFS_CCCTRL}, {24'h0, ctl});
    bus(1'b1, OFS_STATUS, 32'h7);
    bus(1'b1, {1'b0, OFS_MODE}, {24'h0, mode});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog covers the 64K-cycle wrap test plus a wide margin
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values and an unmapped address
    bus(1'b0, {1'b0, OFS_PRESCALE}, 32'h0);
    chk(v, {24'h0, PRESCALE_RST});
    bus(1'b0, {1'b0, OFS_CCCTRL}, 32'h0);
    chk(v, {24'h0, CCCTRL_RST});
    bus(1'b0, OFS_CCA, 32'h0);
    chk(v, {16'h0, CC_RST});
    bus(1'b0, 5'h03, 32'h0);
    chk(v, 32'h0);
    $display("test reset done");
    // Fall, rise and both edge codes on pin A capture into register B
    bus(1'b1, OFS_MASK, 32'h7);
    for (int i = 0; i < 3; i++) begin
      code = (i == 2) ? EDGE_BOTH : 2'(i);
      setup({2'h0, code, 4'h0}, 8'h04, 8'h01);
      la <= 1'b1;
      repeat (10) @(posedge clk);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(32'(v[ST_B]), 32'(code != EDGE_FALL));
      chk(32'(irq), 32'(code != EDGE_FALL));
      bus(1'b1, OFS_STATUS, 32'h7);
      la <= 1'b0;
      repeat (10) @(posedge clk);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(32'(v[ST_B]), 32'(code != EDGE_RISE));
      bus(1'b1, OFS_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      bus(1'b1, OFS_MASK, 32'h7);
      bus(1'b1, OFS_STATUS, 32'h7);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
    end
    // Pin B edge captures into register A
    setup(8'h40, 8'h01, 8'h01);
    lb <= 1'b1;
    repeat (10) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(v & 32'h3, 32'h1);
    lb <= 1'b0;
    $display("test edge codes done");
    // Glitch rejected, then width from two capture registers
    setup(8'h10, 8'h07, 8'h01);
    seed = xs(seed);
    w = 20 + int'(seed[5:0]);
    pulse_a(1, 10);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(v & 32'h3, 32'h0);
    pulse_a(w, 10);
    bus(1'b0, OFS_CCB, 32'h0);
    b = v[15:0];
    bus(1'b0, OFS_CCA, 32'h0);
    chk({16'h0, v[15:0] - b}, 32'(w));
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(v & 32'h3, 32'h3);
    setup(8'h30, 8'h07, 8'h01);
    pulse_a(w, 10);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(32'(v[ST_A]), 32'h0);
    $display("test two registers done");
    // Restart: capture difference equals period difference
    setup(8'h10, 8'h04, 8'h02);
    seed = xs(seed);
    w = int'(seed[4:0]);
    pulse_a(20, 20);
    bus(1'b0, OFS_CCB, 32'h0);
    pulse_a(20, 20);
    bus(1'b0, OFS_CCB, 32'h0);
    b = v[15:0];
    pulse_a(20, 20 + w);
    bus(1'b0, OFS_CCB, 32'h0);
    pulse_a(20, 20);
    bus(1'b0, OFS_CCB, 32'h0);
    chk({16'h0, v[15:0] - b}, 32'(w));
    $display("test restart done");
    // Event counting up to a compare value of three
    setup(8'h10, 8'h00, 8'h00);
    bus(1'b1, OFS_CCA, 32'h3);
    bus(1'b1, {1'b0, OFS_MODE}, 32'h3);
    pulse_a(40, 40);
    pulse_a(40, 40);
    bus(1'b0, {1'b0, OFS_COUNT}, 32'h0);
    chk(v, 32'h2);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(32'(v[ST_A]), 32'h0);
    pulse_a(40, 40);
    bus(1'b0, {1'b0, OFS_COUNT}, 32'h0);
    chk(v, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(32'(v[ST_A]), 32'h1);
    $display("test event counter done");
    // Divide-by-four count clock: 44 edges give 11 steps
    setup(8'h01, 8'h00, 8'h01);
    bus(1'b0, {1'b0, OFS_COUNT}, 32'h0);
    b = v[15:0];
    repeat (41) @(posedge clk);
    bus(1'b0, {1'b0, OFS_COUNT}, 32'h0);
    chk({16'h0, v[15:0] - b}, 32'h0000_000B);
    // Pin A edges as the count clock in free-running mode
    setup(8'h13, 8'h00, 8'h01);
    repeat (3) pulse_a(40, 40);
    bus(1'b0, {1'b0, OFS_COUNT}, 32'h0);
    chk(v, 32'h0000_0003);
    $display("test count clocks done");
    // Clock enable low freezes the counter for ten edges
    setup(8'h00, 8'h00, 8'h01);
    bus(1'b0, {1'b0, OFS_COUNT}, 32'h0);
    b = v[15:0];
    repeat (10) @(posedge clk);
    bus(1'b0, {1'b0, OFS_COUNT}, 32'h0);
    w = int'(v[15:0] - b);
    b = v[15:0];
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    bus(1'b0, {1'b0, OFS_COUNT}, 32'h0);
    chk({16'h0, v[15:0] - b}, 32'(w - 10));
    // Free-running wrap from maximum sets the overflow bit
    repeat (65540) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(32'(v[ST_OVF]), 32'h1);
    $display("test freeze and wrap done");
    give_verdict();
  end
endmodule
